// *** design/tg_consts.svh ***
// constants for the timing generator and operating mode controller
//
// Operation
// - two-stage prescaler, 21-stage divider, machine cycle counters
// - prescaler and divider cleared on reset, stop entry/exit
// - stage7 source bit: 0 fast/256, 1 slow
// - slow-run and sleep force slow clock into stage7
// - warm-up after fast stop feeds stage6 into stage7
// - machine cycle is four states S0 to S3
// - single-clock main clock from fast clock only
// - reset enters single-clock fast-run
// - idle bit halts cpu; interrupt returns fast-run
// - wake vectors if master enable, else resumes
// - clock gate stops peripherals until base-timer falling edge
// - gated fast wait exits to single fast-run
// - base-timer latch set on return if enabled
// - gated slow wait returns to slow-run, fast off
// - dual: fast cycles in fast modes, slow in slow
// - main select and fast-osc bit move between run modes
// - fast oscillator off stops and clears stages 1-6
// - dual idle returns dual-run; sleep returns slow-run
// - sleep with fast on keeps fast oscillator running
// - stop halts oscillators; stop pin releases after warm-up
// - reset release of stop returns single fast-run
`ifndef TG_CONSTS_SVH
`define TG_CONSTS_SVH

// -------------------------------------------------------------
// divider structure
// -------------------------------------------------------------
`define TG_PRESCALE_STAGES 2
`define TG_DIVIDER_STAGES 21
`define TG_LOW_STAGES 6
`define TG_MC_STATES 2'h3

// -------------------------------------------------------------
// register indices (byte address is four times the index)
// -------------------------------------------------------------
`define TG_IDX_TGC 8'h36
`define TG_IDX_SC1 8'h38
`define TG_IDX_SC2 8'h39
`define TG_IDX_STAT 8'h3F
`define TG_TGC_RESET 8'h00
`define TG_SC1_RESET 8'h00
`define TG_SC2_RESET 8'h80

// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define TG_TGC_DOUT_EN 7
`define TG_TGC_DOUT_SEL 6:5
`define TG_TGC_DV7 4
`define TG_TGC_BT_EN 3
`define TG_TGC_BT_SEL 2:0
`define TG_SC1_STOP 7
`define TG_SC1_LEVEL 6
`define TG_SC1_RET_SLOW 5
`define TG_SC1_WUT 3:2
`define TG_SC1_RMASK 8'hFC
`define TG_SC2_HOSC 7
`define TG_SC2_LOSC 6
`define TG_SC2_MAIN_SEL 5
`define TG_SC2_IDLE 4
`define TG_SC2_GATE 2
`define TG_SC2_RMASK 8'hF4

// -------------------------------------------------------------
// taps and warm-up counts (oscillator periods)
// -------------------------------------------------------------
`define TG_BT_TAP_TOP 5'd20
`define TG_BT_TAP_STEP 5'd2
`define TG_DOUT_TAP_TOP 5'd12
`define TG_WU_FAST0 196608
`define TG_WU_FAST1 65536
`define TG_WU_FAST2 49152
`define TG_WU_FAST3 16384
`define TG_WU_SLOW0 24576
`define TG_WU_SLOW_RUN_FAST_OFF 8192
`define TG_WU_SLOW_RUN_FAST_ON 192
`define TG_WU_SLOW3 64
`define TG_WU_W 18

`endif

// *** design/tg_pkg.sv ***
// types shared by the timing generator files
package tg_pkg;
	// operating modes
	typedef enum logic [3:0] {
		single_fast_run, single_idle, gated_fast_wait, dual_fast_run, dual_idle,
		slow_run_fast_on, slow_run_fast_off, sleep_fast_on, sleep_fast_off,
		gated_slow_wait, stop_hold, stop_warmup
	} tg_mode_type;
	// source of divider stage seven
	typedef enum logic [1:0] {src_fast8, src_slow, src_stage6} tg_src_type;
endpackage

// *** design/tg_divider.sv ***
// prescaler and 21-stage divider with selectable stage-seven input
`timescale 1ns/1ns
`default_nettype none
`include "tg_consts.svh"
module tg_divider import tg_pkg::*; #(
	parameter int PRE_W = `TG_PRESCALE_STAGES,
	parameter int DIV_W = `TG_DIVIDER_STAGES
) (
	input wire logic pclk, // fast clock
	input wire logic presetn, // async reset, active low
	input wire logic clear, // clears every stage
	input wire logic hold_low, // stops stages one to six
	input wire logic slow_tick, // one pulse per slow clock period
	input wire tg_src_type src, // stage seven input
	output logic [DIV_W-1:0] stages, // divider stage outputs
	output logic stage7_tick // pulse when stage seven advances
);
	logic [PRE_W-1:0] pre_reg;
	logic [`TG_LOW_STAGES-1:0] low_reg;
	logic [DIV_W-`TG_LOW_STAGES-1:0] high_reg;
	logic carry6;

	// one register per counting chain, so each chain has a single driver
	assign stages = {high_reg, low_reg};

	// stage six rolls over: fast clock divided by 2^8
	assign carry6 = !hold_low && (&pre_reg) && (&low_reg);

	// stage seven input mux
	always_comb begin
		case (src)
			src_slow: stage7_tick = slow_tick;
			src_stage6: stage7_tick = carry6;
			default: stage7_tick = carry6;
		endcase
	end

	// prescaler, held at zero while the fast oscillator is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pre_reg <= '0;
		else if (clear || hold_low)
			pre_reg <= '0;
		else
			pre_reg <= pre_reg + 1'b1;
	end

	// stages one to six: held at zero, giving no output, while fast clock is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_reg <= '0;
		else if (clear || hold_low)
			low_reg <= '0;
		else if (&pre_reg)
			low_reg <= low_reg + 1'b1;
	end

	// stages seven to twenty-one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			high_reg <= '0;
		else if (clear)
			high_reg <= '0;
		else if (stage7_tick)
			high_reg <= high_reg + 1'b1;
	end
endmodule
`default_nettype wire

// *** design/tg_mode_ctrl.sv ***
// timing generator and operating mode controller with apb registers
`timescale 1ns/1ns
`default_nettype none
`include "tg_consts.svh"
module tg_mode_ctrl import tg_pkg::*; #(
	parameter int WU_FAST0 = `TG_WU_FAST0,
	parameter int WU_FAST1 = `TG_WU_FAST1,
	parameter int WU_FAST2 = `TG_WU_FAST2,
	parameter int WU_FAST3 = `TG_WU_FAST3,
	parameter int WU_SLOW0 = `TG_WU_SLOW0,
	parameter int WU_SLOW_RUN_FAST_OFF = `TG_WU_SLOW_RUN_FAST_OFF,
	parameter int WU_SLOW_RUN_FAST_ON = `TG_WU_SLOW_RUN_FAST_ON,
	parameter int WU_SLOW3 = `TG_WU_SLOW3
) (
	input wire logic pclk, // 10 MHz clock, also the fast clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic slow_osc_in, // slow clock pin
	input wire logic stop_pin, // stop release pin, active high
	input wire logic irq_req, // any peripheral or external request
	input wire logic interrupt_master_enable, // core master enable
	input wire logic base_timer_irq_enable, // base timer individual enable
	output logic cpu_run, // core and watchdog clocked
	output logic periph_clk_on, // clock fed to peripherals
	output logic fast_osc_on, // fast oscillator enabled
	output logic slow_osc_on, // slow oscillator enabled
	output logic slow_pins_as_port, // slow oscillator pins free as ports
	output logic main_tick, // main system clock enable pulse
	output logic [1:0] mc_state, // machine cycle state S0..S3
	output logic wake_vectored, // wake pulse, interrupt will be taken
	output logic wake_resume, // wake pulse, continue after idle entry
	output logic base_timer_interrupt, // base timer latch set pulse
	output logic base_timer_service, // latch set and all enables on
	output logic divider_output, // selected divider tap
	output logic [`TG_DIVIDER_STAGES-1:0] div_stages // divider stages
);
	tg_mode_type mode_reg, run_next;
	tg_src_type src;
	logic [7:0] tgc_reg, sc1_reg, sc2_reg;
	logic slow_s1, slow_s2, slow_s3, stop_s1, stop_s2, stop_s3;
	logic slow_tick, stop_release, div_clear, hold_low, stage7_tick;
	logic bt_prev_reg, bt_fall, bt_en_latch_reg, from_fast_reg;
	logic [`TG_WU_W-1:0] wu_cnt_reg;
	logic wu_done, wu_tick, wake, in_slow, gated;
	logic wr, rd_setup, hit;
	logic [7:0] idx, rdata;

	// tap index of the base timer source, indexed by its 3-bit select
	function automatic logic [4:0] bt_tap(input logic [2:0] sel);
		bt_tap = `TG_BT_TAP_TOP - 5'(sel * `TG_BT_TAP_STEP);
	endfunction

	// warm-up length in oscillator periods
	function automatic logic [`TG_WU_W-1:0] wu_limit(input logic [1:0] sel, input logic slow);
		case ({slow, sel})
			3'h0: wu_limit = `TG_WU_W'(WU_FAST0);
			3'h1: wu_limit = `TG_WU_W'(WU_FAST1);
			3'h2: wu_limit = `TG_WU_W'(WU_FAST2);
			3'h3: wu_limit = `TG_WU_W'(WU_FAST3);
			3'h4: wu_limit = `TG_WU_W'(WU_SLOW0);
			3'h5: wu_limit = `TG_WU_W'(WU_SLOW_RUN_FAST_OFF);
			3'h6: wu_limit = `TG_WU_W'(WU_SLOW_RUN_FAST_ON);
			default: wu_limit = `TG_WU_W'(WU_SLOW3);
		endcase
	endfunction

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	// the third stage only serves edge detection, never the first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{slow_s1, slow_s2, slow_s3} <= 3'h0;
			{stop_s1, stop_s2, stop_s3} <= 3'h0;
		end else begin
			{slow_s1, slow_s2, slow_s3} <= {slow_osc_in, slow_s1, slow_s2};
			{stop_s1, stop_s2, stop_s3} <= {stop_pin, stop_s1, stop_s2};
		end
	end
	// slow clock counts only while its oscillator is enabled
	assign slow_tick = slow_s2 && !slow_s3 && slow_osc_on;
	assign stop_release = sc1_reg[`TG_SC1_LEVEL] ? stop_s2 : (stop_s2 && !stop_s3);

	// -------------------------------------------------------------
	// apb slave, zero wait states, read data captured in setup
	// -------------------------------------------------------------
	assign idx = paddr[9:2];
	assign hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
		(idx == `TG_IDX_TGC || idx == `TG_IDX_SC1 || idx == `TG_IDX_SC2 || idx == `TG_IDX_STAT);
	assign wr = psel && penable && pwrite && hit;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	// read mux; the clock select bit reads back the live main clock
	always_comb begin
		case (idx)
			`TG_IDX_TGC: rdata = tgc_reg;
			`TG_IDX_SC1: rdata = sc1_reg & `TG_SC1_RMASK;
			`TG_IDX_SC2: rdata = {sc2_reg[7:6], in_slow, sc2_reg[4:0]} & `TG_SC2_RMASK;
			`TG_IDX_STAT: rdata = 8'(mode_reg);
			default: rdata = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
			prdata <= {24'h00_0000, rdata};
	end

	// timing generator control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tgc_reg <= `TG_TGC_RESET;
		else if (wr && idx == `TG_IDX_TGC)
			tgc_reg <= pwdata[7:0];
	end

	// system control one; the stop bit clears itself once stop is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sc1_reg <= `TG_SC1_RESET;
		else if (wr && idx == `TG_IDX_SC1)
			sc1_reg <= pwdata[7:0];
		else if (mode_reg == stop_hold)
			sc1_reg[`TG_SC1_STOP] <= 1'b0;
	end

	// system control two; idle and gate bits clear on wake,
	// fast oscillator bit clears on a return from stop to slow-run with fast off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc2_reg <= `TG_SC2_RESET;
		end else if (wr && idx == `TG_IDX_SC2) begin
			sc2_reg <= pwdata[7:0];
		end else begin
			if (wake || (gated && bt_fall)) begin
				sc2_reg[`TG_SC2_IDLE] <= 1'b0;
				sc2_reg[`TG_SC2_GATE] <= 1'b0;
			end
			if (mode_reg == stop_warmup && wu_done && sc1_reg[`TG_SC1_RET_SLOW])
				sc2_reg[`TG_SC2_HOSC] <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// mode control
	// -------------------------------------------------------------
	assign in_slow = mode_reg inside {slow_run_fast_on, slow_run_fast_off, sleep_fast_on,
		sleep_fast_off, gated_slow_wait};
	assign gated = (mode_reg == gated_fast_wait) || (mode_reg == gated_slow_wait);
	assign wake = irq_req && (mode_reg inside {single_idle, dual_idle, sleep_fast_on,
		sleep_fast_off});

	// run mode chosen by the oscillator and clock select bits
	always_comb begin
		if (!sc2_reg[`TG_SC2_HOSC])
			run_next = slow_run_fast_off;
		else if (sc2_reg[`TG_SC2_LOSC] && sc2_reg[`TG_SC2_MAIN_SEL])
			run_next = slow_run_fast_on;
		else if (sc2_reg[`TG_SC2_LOSC])
			run_next = dual_fast_run;
		else
			run_next = single_fast_run;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= single_fast_run;
		end else begin
			case (mode_reg)
				single_fast_run, dual_fast_run, slow_run_fast_on, slow_run_fast_off: begin
					if (sc1_reg[`TG_SC1_STOP])
						mode_reg <= stop_hold;
					else if (sc2_reg[`TG_SC2_GATE])
						mode_reg <= in_slow ? gated_slow_wait : gated_fast_wait;
					else if (sc2_reg[`TG_SC2_IDLE] && mode_reg == single_fast_run)
						mode_reg <= single_idle;
					else if (sc2_reg[`TG_SC2_IDLE] && mode_reg == dual_fast_run)
						mode_reg <= dual_idle;
					else if (sc2_reg[`TG_SC2_IDLE])
						mode_reg <= sc2_reg[`TG_SC2_HOSC] ? sleep_fast_on : sleep_fast_off;
					else
						mode_reg <= run_next;
				end
				single_idle: if (irq_req) mode_reg <= single_fast_run;
				dual_idle: if (irq_req) mode_reg <= dual_fast_run;
				sleep_fast_off: if (irq_req) mode_reg <= slow_run_fast_off;
				sleep_fast_on: if (irq_req) mode_reg <= slow_run_fast_on;
				gated_fast_wait: if (bt_fall) mode_reg <= single_fast_run;
				gated_slow_wait: if (bt_fall) mode_reg <= slow_run_fast_off;
				stop_hold: if (stop_release) mode_reg <= stop_warmup;
				stop_warmup: begin
					if (wu_done)
						mode_reg <= sc1_reg[`TG_SC1_RET_SLOW] ? slow_run_fast_off : run_next;
				end
				default: mode_reg <= single_fast_run;
			endcase
		end
	end

	// remember where stop came from, for the warm-up source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			from_fast_reg <= 1'b1;
		else if (mode_reg != stop_hold && mode_reg != stop_warmup)
			from_fast_reg <= !in_slow;
	end

	// warm-up counter; fast return counts fast periods, slow return slow periods
	assign wu_tick = from_fast_reg ? 1'b1 : slow_tick;
	assign wu_done = wu_tick && (wu_cnt_reg >= wu_limit(sc1_reg[`TG_SC1_WUT], !from_fast_reg) - 1'b1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wu_cnt_reg <= '0;
		else if (mode_reg != stop_warmup)
			wu_cnt_reg <= '0;
		else if (wu_tick)
			wu_cnt_reg <= wu_cnt_reg + 1'b1;
	end

	// -------------------------------------------------------------
	// timing generator
	// -------------------------------------------------------------
	// clear on stop entry and on release
	assign div_clear = (mode_reg == stop_hold) || (mode_reg == stop_warmup && wu_done);
	assign hold_low = !fast_osc_on || (mode_reg == stop_hold);

	always_comb begin
		if (mode_reg == stop_warmup && from_fast_reg)
			src = src_stage6;
		else if (in_slow)
			src = src_slow;
		else
			src = tgc_reg[`TG_TGC_DV7] ? src_slow : src_fast8;
	end

	tg_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.clear(div_clear),
		.hold_low(hold_low),
		.slow_tick(slow_tick),
		.src(src),
		.stages(div_stages),
		.stage7_tick(stage7_tick)
	);

	// base timer source edge; gated waits end on its falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bt_prev_reg <= 1'b0;
		else
			bt_prev_reg <= div_stages[bt_tap(tgc_reg[`TG_TGC_BT_SEL])];
	end
	assign bt_fall = bt_prev_reg && !div_stages[bt_tap(tgc_reg[`TG_TGC_BT_SEL])];

	// enable state captured on entry to a gated wait, whatever its value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bt_en_latch_reg <= 1'b0;
		else if (!gated)
			bt_en_latch_reg <= tgc_reg[`TG_TGC_BT_EN];
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign main_tick = in_slow ? slow_tick : (fast_osc_on && mode_reg != stop_warmup);

	// machine cycle states advance on every main clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mc_state <= 2'h0;
		else if (main_tick)
			mc_state <= (mc_state == `TG_MC_STATES) ? 2'h0 : mc_state + 2'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_vectored <= 1'b0;
			wake_resume <= 1'b0;
			base_timer_interrupt <= 1'b0;
			base_timer_service <= 1'b0;
			divider_output <= 1'b0;
		end else begin
			wake_vectored <= wake && interrupt_master_enable;
			wake_resume <= wake && !interrupt_master_enable;
			base_timer_interrupt <= gated && bt_fall && bt_en_latch_reg;
			base_timer_service <= gated && bt_fall && bt_en_latch_reg && interrupt_master_enable &&
				base_timer_irq_enable && tgc_reg[`TG_TGC_BT_EN];
			divider_output <= tgc_reg[`TG_TGC_DOUT_EN] &&
				div_stages[`TG_DOUT_TAP_TOP - 5'(tgc_reg[`TG_TGC_DOUT_SEL])];
		end
	end

	assign cpu_run = mode_reg inside {single_fast_run, dual_fast_run, slow_run_fast_on,
		slow_run_fast_off};
	assign periph_clk_on = !gated && mode_reg != stop_hold && mode_reg != stop_warmup;
	assign fast_osc_on = sc2_reg[`TG_SC2_HOSC] && mode_reg != stop_hold &&
		!(mode_reg inside {sleep_fast_off, gated_slow_wait, slow_run_fast_off});
	assign slow_osc_on = sc2_reg[`TG_SC2_LOSC] && mode_reg != stop_hold;
	assign slow_pins_as_port = !sc2_reg[`TG_SC2_LOSC];

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	property p_stop_clears;
		@(posedge pclk) disable iff (!presetn)
		(mode_reg != stop_hold) ##1 (mode_reg == stop_hold) |=> (div_stages == '0);
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("divider not cleared in stop");

	property p_slow_src;
		@(posedge pclk) disable iff (!presetn)
		in_slow |-> (src == src_slow);
	endproperty
	a_slow_src: assert property (p_slow_src) else $error("slow mode not fed slow clock");

	property p_warm_src;
		@(posedge pclk) disable iff (!presetn)
		(mode_reg == stop_warmup && from_fast_reg) |-> (src == src_stage6) && !hold_low;
	endproperty
	a_warm_src: assert property (p_warm_src) else $error("warm-up not fed from stage six");

	property p_mc_step;
		@(posedge pclk) disable iff (!presetn)
		main_tick |=> (mc_state == 2'($past(mc_state) + 2'h1));
	endproperty
	a_mc_step: assert property (p_mc_step) else $error("machine state did not step");

	property p_idle_wake;
		@(posedge pclk) disable iff (!presetn)
		(mode_reg == single_idle && irq_req) |=> (mode_reg == single_fast_run) && cpu_run;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake to fast-run");

	property p_wake_kind;
		@(posedge pclk) disable iff (!presetn)
		wake |=> (wake_vectored == $past(interrupt_master_enable)) && (wake_resume != wake_vectored);
	endproperty
	a_wake_kind: assert property (p_wake_kind) else $error("wake kind wrong");

	property p_gate_exit;
		@(posedge pclk) disable iff (!presetn)
		(mode_reg == gated_fast_wait && bt_fall) |=> (mode_reg == single_fast_run) && periph_clk_on;
	endproperty
	a_gate_exit: assert property (p_gate_exit) else $error("gated wait exit wrong");

	property p_bt_latch;
		@(posedge pclk) disable iff (!presetn)
		(gated && bt_fall && bt_en_latch_reg) |=> base_timer_interrupt && !gated;
	endproperty
	a_bt_latch: assert property (p_bt_latch) else $error("base timer latch not set");

	property p_low_hold;
		@(posedge pclk) disable iff (!presetn)
		hold_low [*2] |-> (div_stages[`TG_LOW_STAGES-1:0] == '0);
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("low stages ran with fast off");
endmodule
`default_nettype wire

// *** sim/test_timing_generator_mode_control.sv ***
// self-checking bench for the timing generator and mode controller
`timescale 1ns/1ns
`default_nettype none
module test_timing_generator_mode_control;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow_osc_in = 0;
	logic stop_pin = 0, irq_req = 0, master_en = 0, btie = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, seed = 32'hF435, x;
	logic pready, pslverr, cpu_run, periph_clk_on, fast_osc_on, slow_osc_on, slow_pins_as_port;
	logic main_tick, wake_vectored, wake_resume, base_timer_interrupt, base_timer_service;
	logic divider_output;
	logic [1:0] mc_state;
	logic [20:0] div_stages;
	logic [2:0] scnt = 0;
	int fails = 0, check_count = 0, n, i;

	// ---------------------------------------------------------
	// clock, slow clock at one eighth of pclk, device
	// ---------------------------------------------------------
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		scnt <= scnt + 3'h1;
		slow_osc_in <= scnt[2];
	end
	// short warm-up counts keep the stop test brief
	tg_mode_ctrl #(.WU_FAST3(10), .WU_SLOW3(2)) tg_mode_ctrl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slow_osc_in(slow_osc_in), .stop_pin(stop_pin), .irq_req(irq_req),
		.interrupt_master_enable(master_en), .base_timer_irq_enable(btie), .cpu_run(cpu_run),
		.periph_clk_on(periph_clk_on), .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on),
		.slow_pins_as_port(slow_pins_as_port), .main_tick(main_tick), .mc_state(mc_state),
		.wake_vectored(wake_vectored), .wake_resume(wake_resume),
		.base_timer_interrupt(base_timer_interrupt), .base_timer_service(base_timer_service),
		.divider_output(divider_output), .div_stages(div_stages));

	// ---------------------------------------------------------
	// helpers
	// ---------------------------------------------------------
	function logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one apb transfer, then one idle cycle so mode updates land before the next read
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd_mode(input logic [31:0] m);
		apb(1'b0, 12'hFC, 0);
		chk(rd, m);
	endtask
	// bounded wait for the base timer latch pulse after a gated wait
	task wait_bt;
		n = 0;
		while (base_timer_interrupt !== 1'b1 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		chk(base_timer_interrupt, 1);
	endtask
	task wake(input logic m);
		irq_req <= 1'b1;
		@(posedge pclk);
		@(posedge pclk);
		chk({wake_vectored, wake_resume}, {m, ~m});
		irq_req <= 1'b0;
	endtask

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'hD8, 0);
		chk(rd, 32'h00);
		apb(1'b0, 12'hE4, 0);
		chk(rd, 32'h80);
		rd_mode(0);
		chk({cpu_run, periph_clk_on, fast_osc_on, slow_pins_as_port, slow_osc_on}, 5'h1E);
		chk(main_tick, 1);
		x = mc_state;
		@(posedge pclk);
		chk(mc_state, 2'(x + 1));
		apb(1'b0, 12'h004, 0);
		chk(err, 1);
		chk(rd, 0);
		// stage seven source kept at zero, single-clock software may not set it
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			x = seed & 32'hEF;
			apb(1'b1, 12'hD8, x);
			apb(1'b0, 12'hD8, 0);
			chk(rd, x);
		end
		$display("reset and register test done");
		for (i = 0; i < 2; i++) begin
			master_en <= i[0];
			apb(1'b1, 12'hE4, 32'h90);
			rd_mode(1);
			chk(cpu_run, 0);
			wake(i[0]);
			rd_mode(0);
		end
		$display("idle test done");
		master_en <= 1'b1;
		btie <= 1'b1;
		// base timer on the stage seven tap so its falling edge comes within 512 cycles
		apb(1'b1, 12'hD8, 32'h8F);
		apb(1'b1, 12'hE4, 32'h84);
		rd_mode(2);
		chk(periph_clk_on, 0);
		wait_bt();
		chk(base_timer_service, 1);
		rd_mode(0);
		$display("gated fast wait test done");
		apb(1'b1, 12'hE0, 32'hCC);
		rd_mode(10);
		chk(div_stages, 0);
		stop_pin <= 1'b1;
		n = 0;
		do begin
			apb(1'b0, 12'hFC, 0);
			n++;
		end while (rd !== 32'h0 && n < 40);
		chk(rd, 0);
		// divider was cleared at release, so the stage thirteen tap is still low
		chk(divider_output, 0);
		stop_pin <= 1'b0;
		$display("stop test done");
		apb(1'b1, 12'hE4, 32'hC0);
		rd_mode(3);
		chk(slow_pins_as_port, 0);
		chk(slow_osc_on, 1);
		apb(1'b1, 12'hE4, 32'hE0);
		rd_mode(5);
		apb(1'b1, 12'hE4, 32'h60);
		rd_mode(6);
		chk({fast_osc_on, div_stages[5:0]}, 0);
		apb(1'b1, 12'hE4, 32'h70);
		rd_mode(8);
		wake(1'b1);
		rd_mode(6);
		apb(1'b1, 12'hE4, 32'h64);
		rd_mode(9);
		wait_bt();
		rd_mode(6);
		$display("dual clock test done");
		// reset in the middle of stop always comes back to single-clock fast-run
		apb(1'b1, 12'hE0, 32'hA0);
		rd_mode(10);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_mode(0);
		apb(1'b0, 12'hE4, 0);
		chk(rd, 32'h80);
		$display("reset from stop test done");
		end_sim();
	end
	// a hang anywhere ends the run as a mismatch
	initial begin
		repeat (100000) @(posedge pclk);
		fails++;
		end_sim();
	end
endmodule
`default_nettype wire
